// file: include/psw_regs.svh
`ifndef PSW_REGS_SVH
`define PSW_REGS_SVH
`define PSW_OFS_CTRL     4'h0
`define PSW_OFS_DIV      4'h4
`define PSW_OFS_STATUS   4'h8
`define PSW_CTRL_AUTO    0
`define PSW_CTRL_PFD     1
`define PSW_CTRL_RESET   2
`define PSW_CTRL_SWREQ   3
`define PSW_CTRL_RST_VAL 4'h7
`define PSW_DIV_RST_VAL  16'h0101
`define PSW_VCO_NOMINAL  8'h80
`define PSW_LOSS_PERIODS 2
`define PSW_PRIMARY      1'h0
`define PSW_BACKUP       1'h1
`endif

// file: include/psw_pkg.sv
package psw_pkg;
    typedef enum logic [1:0] {PSW_IDLE, PSW_GATE, PSW_SWAP} psw_state_t;
    typedef struct packed {
        logic [7:0] vco_level;
        logic [1:0] state;
        logic       raw_lock;
        logic       locked;
        logic       active;
        logic [1:0] loss;
    } psw_status_t;
    typedef struct packed {
        logic       switch_request;
        logic       pll_reset;
        logic       pfd_enable;
        logic       auto_enable;
    } psw_ctrl_t;
endpackage

// file: verilog/psw_top.sv
`timescale 1ns/1ps
`include "psw_regs.svh"
module psw_top
    import psw_pkg::*;
#(
    parameter int CNT_W       = 12,
    parameter int LOCK_EDGES  = 16,
    parameter int DRIFT_CYCLES = 4096
)(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        primary_reference,
    input  wire logic        backup_reference,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             ref_to_pll,
    output logic             post_scale_counter_zero,
    output logic             locked,
    output logic             active_reference,
    output logic      [1:0]  loss_flags
);
    psw_ctrl_t         ctrl;
    logic [7:0]        high_count;
    logic [7:0]        low_count;
    logic [1:0]        ref_in;
    logic [1:0]        sync1;
    logic [1:0]        sync2;
    logic [1:0]        sync3;
    logic [1:0]        ref_fall;
    logic [1:0]        ref_rise;
    logic [1:0]        loss;
    psw_state_t        state;
    logic              req_prev;
    logic              req_rise;
    logic              auto_start;
    logic              target;
    logic              gated;
    logic              reset_prev;
    logic              raw_lock;
    logic [7:0]        lock_count;
    logic [7:0]        vco_level;
    logic [15:0]       drift_count;
    logic [7:0]        ps_count;
    psw_status_t       status;

    assign ref_in = {backup_reference, primary_reference};

    // both references are sampled on core_clk, which must run well above them
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            sync1 <= 2'h0;
            sync2 <= 2'h0;
            sync3 <= 2'h0;
        end
        else
        begin
            sync1 <= ref_in;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    assign ref_fall = sync3 & ~sync2;
    assign ref_rise = ~sync3 & sync2;

    // per reference: measure period, flag loss when low beyond two periods
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_sense
            logic [CNT_W-1:0] since_rise;
            logic [CNT_W-1:0] period;
            logic [CNT_W-1:0] low_time;
            logic [CNT_W:0]   limit;
            assign limit = {period, 1'b0};
            always_ff @(posedge core_clk)
            begin
                if (!rst_n)
                begin
                    since_rise <= '0;
                    period     <= '0;
                end
                else if (ref_rise[g])
                begin
                    period     <= since_rise;
                    since_rise <= '0;
                end
                else if (since_rise != '1)
                begin
                    since_rise <= since_rise + 1'b1;
                end
            end
            always_ff @(posedge core_clk)
            begin
                if (!rst_n)
                    low_time <= '0;
                else if (sync2[g])
                    low_time <= '0;
                else if (low_time != '1)
                    low_time <= low_time + 1'b1;
            end
            // a still clock has no period yet; saturation of the low timer covers it
            always_ff @(posedge core_clk)
            begin
                if (!rst_n)
                    loss[g] <= 1'b0;
                else if (sync2[g])
                    loss[g] <= 1'b0;
                else if ((period != '0 && {1'b0, low_time} > limit) || low_time == '1)
                    loss[g] <= 1'b1;
            end
        end
    endgenerate

    // register writes
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            ctrl       <= psw_ctrl_t'(`PSW_CTRL_RST_VAL);
            high_count <= 8'(`PSW_DIV_RST_VAL);
            low_count  <= 8'(`PSW_DIV_RST_VAL >> 8);
        end
        else if (reg_wr && reg_addr == `PSW_OFS_CTRL)
        begin
            ctrl <= psw_ctrl_t'(reg_wdata[3:0]);
        end
        else if (reg_wr && reg_addr == `PSW_OFS_DIV)
        begin
            high_count <= reg_wdata[7:0];
            low_count  <= reg_wdata[15:8];
        end
    end

    assign status.vco_level = vco_level;
    assign status.state     = state;
    assign status.raw_lock  = raw_lock;
    assign status.locked    = locked;
    assign status.active    = active_reference;
    assign status.loss      = loss;

    // read data stands in the cycle after the strobe only; unmapped reads zero
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || !reg_rd)
            reg_rdata <= 32'h0;
        else if (reg_addr == `PSW_OFS_CTRL)
            reg_rdata <= {28'h0, ctrl};
        else if (reg_addr == `PSW_OFS_DIV)
            reg_rdata <= {16'h0, low_count, high_count};
        else if (reg_addr == `PSW_OFS_STATUS)
            reg_rdata <= {17'h0, status};
        else
            reg_rdata <= 32'h0;
    end

    // switchover requests: only rising edges of the request bit count
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            req_prev <= 1'b0;
        else
            req_prev <= ctrl.switch_request;
    end

    assign req_rise   = ctrl.switch_request & ~req_prev;
    assign auto_start = ctrl.auto_enable & loss[active_reference];
    assign target     = ~active_reference;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state            <= PSW_IDLE;
            gated            <= 1'b0;
            active_reference <= `PSW_PRIMARY;
        end
        else
        begin
            case (state)
                PSW_IDLE:
                begin
                    // manual mode: request is the only trigger
                    if (req_rise || auto_start)
                        state <= PSW_GATE;
                end
                PSW_GATE:
                begin
                    // a dead current clock gives no falling edge; gate at once
                    if (ref_fall[active_reference] || loss[active_reference])
                    begin
                        gated <= 1'b1;
                        state <= PSW_SWAP;
                    end
                end
                PSW_SWAP:
                begin
                    if (ref_fall[target] && !loss[target])
                    begin
                        active_reference <= target;
                        gated            <= 1'b0;
                        state            <= PSW_IDLE;
                    end
                end
                default:
                begin
                    state <= PSW_IDLE;
                end
            endcase
        end
    end

    // reference into the loop, muxed and gated; select and gate change only while the selected reference is low
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            ref_to_pll <= 1'b0;
        else
            ref_to_pll <= ~gated & sync2[active_reference];
    end

    // vco control model: held by the gate, drifts low, reset to nominal
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || ctrl.pll_reset)
        begin
            vco_level   <= `PSW_VCO_NOMINAL;
            drift_count <= 16'h0;
        end
        else if (!ctrl.pfd_enable)
        begin
            if (drift_count == 16'(DRIFT_CYCLES - 1))
            begin
                drift_count <= 16'h0;
                if (vco_level != 8'h0)
                    vco_level <= vco_level - 8'h1;
            end
            else
            begin
                drift_count <= drift_count + 16'h1;
            end
        end
        else if (!gated && ref_fall[active_reference] && vco_level != `PSW_VCO_NOMINAL)
        begin
            drift_count <= 16'h0;
            vco_level   <= (vco_level < `PSW_VCO_NOMINAL) ? vco_level + 8'h1
                                                          : vco_level - 8'h1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            reset_prev <= 1'b0;
        else
            reset_prev <= ctrl.pll_reset;
    end

    // lock acquisition counts reference edges seen by the detector
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || ctrl.pll_reset)
            lock_count <= 8'h0;
        else if (!ctrl.pfd_enable || gated || loss[active_reference])
            lock_count <= lock_count;
        else if (ref_fall[active_reference] && lock_count != 8'(LOCK_EDGES))
            lock_count <= lock_count + 8'h1;
    end

    // raw lock may toggle; cleared on reset release or lost reference, else it follows the lock count and vco level
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            raw_lock <= 1'b0;
        else if (reset_prev && !ctrl.pll_reset)
            raw_lock <= 1'b0;
        else if (loss[active_reference])
            raw_lock <= 1'b0;
        else
            raw_lock <= (lock_count == 8'(LOCK_EDGES)) && vco_level == `PSW_VCO_NOMINAL;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            locked <= 1'b0;
        else
            locked <= raw_lock & ~ctrl.pll_reset;
    end

    // post-scale counter on core_clk; zero counts act as one
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || ctrl.pll_reset)
        begin
            ps_count                <= 8'h0;
            post_scale_counter_zero <= 1'b0;
        end
        else if (post_scale_counter_zero ? ps_count + 8'h1 >= high_count
                                         : ps_count + 8'h1 >= low_count)
        begin
            ps_count                <= 8'h0;
            post_scale_counter_zero <= ~post_scale_counter_zero;
        end
        else
        begin
            ps_count <= ps_count + 8'h1;
        end
    end

    assign loss_flags = loss;

    a_reset_clears_lock: assert property (@(posedge core_clk) disable iff (!rst_n)
        ctrl.pll_reset |=> !locked && !post_scale_counter_zero && vco_level == `PSW_VCO_NOMINAL)
        else $error("pll reset did not clear outputs");
    a_lock_stage: assert property (@(posedge core_clk) disable iff (!rst_n)
        locked |-> $past(raw_lock))
        else $error("lock output without raw lock");
    a_raw_falls_release: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(ctrl.pll_reset) |=> !raw_lock)
        else $error("raw lock survived reset release");
    a_gate_on_fall: assert property (@(posedge core_clk) disable iff (!rst_n)
        state == PSW_GATE && ref_fall[active_reference] |=> gated && state == PSW_SWAP)
        else $error("reference not gated at falling edge");
    a_swap_moves_mux: assert property (@(posedge core_clk) disable iff (!rst_n)
        state == PSW_SWAP && ref_fall[target] && !loss[target]
        |=> active_reference != $past(active_reference) && !gated)
        else $error("mux did not swap on new reference edge");
    a_swap_waits: assert property (@(posedge core_clk) disable iff (!rst_n)
        state == PSW_SWAP && loss[target] |=> $stable(active_reference))
        else $error("swapped to an absent reference");
    a_req_edge_only: assert property (@(posedge core_clk) disable iff (!rst_n)
        state == PSW_IDLE && !req_rise && !auto_start |=> state == PSW_IDLE)
        else $error("switchover started without a trigger");
    a_loss_on_low: assert property (@(posedge core_clk) disable iff (!rst_n)
        sync2[0] ##1 !sync2[0] [*8] |-> ##[0:1000] (loss[0] || sync2[0]))
        else $error("low primary reference never flagged");
    a_toggling_no_loss: assert property (@(posedge core_clk) disable iff (!rst_n)
        sync2[0] |=> !loss[0])
        else $error("loss flag high while reference toggles");
    a_auto_starts: assert property (@(posedge core_clk) disable iff (!rst_n)
        state == PSW_IDLE && ctrl.auto_enable && loss[active_reference] |=> state == PSW_GATE)
        else $error("auto switchover not started on loss");
    a_gated_ref_low: assert property (@(posedge core_clk) disable iff (!rst_n)
        gated |=> !ref_to_pll)
        else $error("reference passed while gated");
    a_pfd_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !ctrl.pfd_enable && !ctrl.pll_reset |=> lock_count == $past(lock_count))
        else $error("lock count moved with detector off");

    c_auto_swap: cover property (@(posedge core_clk) disable iff (!rst_n)
        auto_start ##[1:1000] $changed(active_reference));
    c_cmd_swap: cover property (@(posedge core_clk) disable iff (!rst_n)
        req_rise ##[1:1000] $changed(active_reference));
    c_relock: cover property (@(posedge core_clk) disable iff (!rst_n)
        $fell(ctrl.pll_reset) ##[1:1000] locked);
endmodule

// file: bench/psw_ref_model.sv
`timescale 1ns/1ps
module psw_ref_model (
    input  wire logic        run_primary,
    input  wire logic        run_backup,
    input  wire logic [15:0] half_primary,
    input  wire logic [15:0] half_backup,
    output logic             primary_reference,
    output logic             backup_reference
);
    // a stopped source parks low, the way a dead oscillator looks to loss detection
    // both sources stay within 20% unless a test deliberately widens the gap
    // one process per source so each pin has a single driver
    initial
    begin
        primary_reference = 1'b0;
        forever
        begin
            #((half_primary == 16'h0000) ? 100 : half_primary);
            primary_reference = run_primary ? ~primary_reference : 1'b0;
        end
    end

    initial
    begin
        backup_reference = 1'b0;
        forever
        begin
            #((half_backup == 16'h0000) ? 110 : half_backup);
            backup_reference = run_backup ? ~backup_reference : 1'b0;
        end
    end
endmodule

// file: bench/tb_pll_ref_switchover_control.sv
`timescale 1ns/1ps
`include "psw_regs.svh"
module tb_pll_ref_switchover_control;
    import psw_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst_n;
    logic        primary_reference;
    logic        backup_reference;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        ref_to_pll;
    logic        post_scale_counter_zero;
    logic        locked;
    logic        active_reference;
    logic [1:0]  loss_flags;
    // set before any process starts, so the source model never sees an unknown period
    logic        run_primary = 1'b1;
    logic        run_backup = 1'b1;
    logic [15:0] half_primary = 16'h0064;
    logic [15:0] half_backup = 16'h006E;
    logic        rd_seen = 1'b0;
    logic [31:0] seed = 32'h77BB6699;
    logic [31:0] exp_q[$];
    logic [31:0] mask_q[$];
    int          errors = 0;
    int          num_checks = 0;

    always #2.5 core_clk = ~core_clk;

    psw_top #(.CNT_W(12), .LOCK_EDGES(4), .DRIFT_CYCLES(8)) u_psw_top (
        .core_clk(core_clk), .rst_n(rst_n),
        .primary_reference(primary_reference), .backup_reference(backup_reference),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ref_to_pll(ref_to_pll),
        .post_scale_counter_zero(post_scale_counter_zero), .locked(locked),
        .active_reference(active_reference), .loss_flags(loss_flags)
    );

    psw_ref_model u_psw_ref_model (
        .run_primary(run_primary), .run_backup(run_backup),
        .half_primary(half_primary), .half_backup(half_backup),
        .primary_reference(primary_reference), .backup_reference(backup_reference)
    );

    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic sel_bit(input int which);
        case (which)
            0: return locked;
            1: return active_reference;
            2: return loss_flags[0];
            3: return loss_flags[1];
            5: return ref_to_pll;
            default: return post_scale_counter_zero;
        endcase
    endfunction

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // sample one ns after the edge so the design's updates have landed
    task automatic step(input int n);
        repeat (n)
        begin
            @(posedge core_clk);
            #1;
        end
    endtask

    task automatic wait_until(input int which, input logic val, input int bound);
        int n;
        n = 0;
        while (sel_bit(which) !== val && n < bound)
        begin
            step(1);
            n++;
        end
        if (n >= bound)
        begin
            errors++;
            $display("wrong value wait %0d expected %b seen %b", which, val, sel_bit(which));
            print_verdict();
        end
    endtask

    // an extra edge before each strobe keeps back-to-back calls from double driving it
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e & m);
        mask_q.push_back(m);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        @(posedge core_clk);
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge core_clk)
    begin
        if (rd_seen)
        begin
            if (exp_q.size() == 0)
                check_word("reg_rdata_unexpected", 32'h0000_0000, 32'hFFFF_FFFF);
            else
                check_word("reg_rdata", exp_q.pop_front(), reg_rdata & mask_q.pop_front());
        end
        rd_seen <= reg_rd;
    end

    task automatic duty(input int h, input int l);
        int n;
        wait_until(4, 1'b0, 600);
        wait_until(4, 1'b1, 600);
        n = 0;
        while (sel_bit(4) === 1'b1 && n < 600)
        begin
            step(1);
            n++;
        end
        check_word("high_time", 32'(h), 32'(n));
        n = 0;
        while (sel_bit(4) === 1'b0 && n < 600)
        begin
            step(1);
            n++;
        end
        check_word("low_time", 32'(l), 32'(n));
    endtask

    initial
    begin
        logic [31:0] r;
        rst_n = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        reg_read(`PSW_OFS_CTRL, 32'h0000_0007, 32'hFFFF_FFFF);
        reg_read(`PSW_OFS_DIV, 32'h0000_0101, 32'hFFFF_FFFF);
        reg_read(`PSW_OFS_STATUS, 32'h0000_0000, 32'h0000_001F);
        reg_write(4'hC, xorshift());
        reg_read(4'hC, 32'h0000_0000, 32'hFFFF_FFFF);
        step(20);
        check_word("held_output", 32'h0, {31'h0, post_scale_counter_zero});
        $display("test reset done");
        // references already run steadily before the pll reset is released
        reg_write(`PSW_OFS_CTRL, 32'h0000_0003);
        wait_until(0, 1'b1, 2000);
        reg_read(`PSW_OFS_STATUS, 32'h0000_0018, 32'h0000_001F);
        wait_until(5, 1'b1, 100);
        reg_write(`PSW_OFS_CTRL, 32'h0000_0007);
        step(4);
        check_word("lock_in_reset", 32'h0, {31'h0, locked});
        check_word("out_in_reset", 32'h0, {31'h0, post_scale_counter_zero});
        reg_write(`PSW_OFS_CTRL, 32'h0000_0003);
        wait_until(0, 1'b1, 2000);
        $display("test lock done");
        for (int i = 0; i < 4; i++)
        begin
            r = xorshift();
            reg_write(`PSW_OFS_DIV, {16'h0, 5'h0, r[5:3], 5'h0, r[2:0]} + 32'h0000_0101);
            step(4);
            duty(int'(r[2:0]) + 1, int'(r[5:3]) + 1);
        end
        reg_write(`PSW_OFS_DIV, 32'h0000_0000);
        step(4);
        duty(1, 1);
        $display("test duty done");
        // request held for well over three slow periods before it drops
        reg_write(`PSW_OFS_CTRL, 32'h0000_000B);
        wait_until(1, 1'b1, 600);
        // phase matters here: pulse the pll reset after the swap and wait for lock again
        reg_write(`PSW_OFS_CTRL, 32'h0000_000F);
        reg_write(`PSW_OFS_CTRL, 32'h0000_000B);
        wait_until(0, 1'b1, 2000);
        step(150);
        check_word("loss_manual", 32'h0, {30'h0, loss_flags});
        reg_write(`PSW_OFS_CTRL, 32'h0000_0003);
        step(150);
        check_word("active_after_fall", 32'h1, {31'h0, active_reference});
        reg_write(`PSW_OFS_CTRL, 32'h0000_000B);
        wait_until(1, 1'b0, 600);
        step(150);
        reg_write(`PSW_OFS_CTRL, 32'h0000_0003);
        $display("test override done");
        run_primary = 1'b0;
        wait_until(2, 1'b1, 1000);
        wait_until(1, 1'b1, 1000);
        reg_read(`PSW_OFS_STATUS, 32'h0000_0005, 32'h0000_0007);
        run_primary = 1'b1;
        wait_until(2, 1'b0, 1000);
        run_backup = 1'b0;
        wait_until(3, 1'b1, 1000);
        wait_until(1, 1'b0, 1000);
        run_backup = 1'b1;
        wait_until(3, 1'b0, 1000);
        $display("test automatic done");
        // manual mode with a gap far over 20 percent, target held dead at first
        reg_write(`PSW_OFS_CTRL, 32'h0000_0002);
        run_backup = 1'b0;
        half_backup = 16'h0028;
        step(300);
        reg_write(`PSW_OFS_CTRL, 32'h0000_000A);
        step(300);
        check_word("wait_dead_target", 32'h0, {31'h0, active_reference});
        check_word("gated_ref", 32'h0, {31'h0, ref_to_pll});
        run_backup = 1'b1;
        wait_until(1, 1'b1, 1000);
        $display("test manual done");
        // pfd gated off: vco level drifts below nominal, clearing its top bit
        reg_write(`PSW_OFS_CTRL, 32'h0000_0000);
        step(200);
        reg_read(`PSW_OFS_STATUS, 32'h0000_0000, 32'h0000_4000);
        step(2);
        $display("test drift done");
        print_verdict();
    end
endmodule
